// [swc_config_decode.sv]
// Purpose: Decode supervisor and watchdog configuration words into settings
// Assumes: Words, blank flag and LOW_VOLTAGE_PROGRAMMING_ENABLE come from the NVM domain; core inputs
//          share this clock
// Notes:   Settings are registered; a word change shows three edges later
//          Stack flags set even with fault reset off; depth then saturates
module swc_config_decode
  import swc_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // Nonvolatile configuration (other domain)
  input  wire logic [13:0]        supervisor_config_raw,
  input  wire logic [13:0]        watchdog_config_raw,
  input  wire logic               low_voltage_programming_enable,
  input  wire logic               config_blank,
  // Core status and controls
  input  wire logic               sleep_active,
  input  wire logic               software_brownout_enable,
  input  wire logic               software_watchdog_enable,
  // Return stack events
  input  wire logic               stack_push,
  input  wire logic               stack_pop,
  input  wire logic               stack_flag_clear,
  // Pin-select lock write port
  input  wire logic               pin_select_unlock_ok,
  input  wire logic               pin_select_lock_write,
  input  wire logic               pin_select_lock_wdata,
  // Decoded settings
  output swc_supervisor_type      supervisor_settings,
  output swc_watchdog_type        watchdog_settings,
  // Readback words
  output logic [13:0]             supervisor_config_word,
  output logic [13:0]             watchdog_config_word,
  // Stack supervision
  output logic                    stack_fault_reset,
  output logic                    stack_overflow_flag,
  output logic                    stack_underflow_flag,
  output logic [4:0]              stack_depth,
  // Pin-select lock state
  output logic                    pin_select_lock_bit,
  output logic                    pin_select_lock_final
);

  // Blank flag and LOW_VOLTAGE_PROGRAMMING_ENABLE ride in the same synchroniser as both words,
  // so all four always move together
  localparam int SYNC_WIDTH = 2 * CFG_WIDTH + 2;

  logic [SYNC_WIDTH-1:0] nvm_async;
  logic [SYNC_WIDTH-1:0] nvm_sync;
  logic [13:0]           sup_word;
  logic [13:0]           wdt_word;
  logic                  lvp_sync;
  logic                  blank_sync;

  // Shared decode of the two-bit operating mode fields
  // Mode 10 trusts the core's sleep flag; Sleep is not tracked here
  function automatic logic mode_active(input logic [1:0] mode,
                                       input logic       asleep,
                                       input logic       soft_enable);
    logic active;
    active = 1'b0;
    unique case (mode)
      MODE_ALWAYS: active = 1'b1;
      MODE_AWAKE:  active = !asleep;
      MODE_SOFT:   active = soft_enable;
      MODE_OFF:    active = 1'b0;
    endcase
    return active;
  endfunction

  // Closed share of the period in eighths; 110 is open like 111
  function automatic logic [2:0] window_closed(input logic [2:0] code);
    logic [2:0] eighths;
    eighths = 3'h0;
    unique case (code)
      3'h7:    eighths = 3'h0;
      3'h6:    eighths = 3'h0;
      3'h5:    eighths = 3'h2;
      3'h4:    eighths = 3'h3;
      3'h3:    eighths = 3'h4;
      3'h2:    eighths = 3'h5;
      3'h1:    eighths = 3'h6;
      3'h0:    eighths = 3'h7;
    endcase
    return eighths;
  endfunction

  // Only the fully open software code escapes keyed access
  function automatic logic window_soft(input logic [2:0] code);
    return (code == WDT_WIN_SOFT);
  endfunction

  // Reserved codes give no source; the counter must treat them as stopped
  function automatic swc_wdt_clk_type clock_source(input logic [2:0] code);
    swc_wdt_clk_type src;
    src = SWC_CLK_NONE;
    if (code == WDT_CLK_LFOSC)
      src = SWC_CLK_LFOSC;
    else if (code == WDT_CLK_MFOSC16)
      src = SWC_CLK_MFOSC16;
    else if (code == WDT_CLK_SOFT)
      src = SWC_CLK_SOFT;
    return src;
  endfunction

  // Codes past the last ratio fall back to 1:32, the shortest period
  function automatic logic [4:0] period_log2(input logic [4:0] code);
    logic [4:0] log2;
    log2 = PERIOD_BASE_LOG2;
    if (code <= PERIOD_MAX_CODE)
      log2 = PERIOD_BASE_LOG2 + code;
    return log2;
  endfunction

  // NVM values come from another domain, so they cross two flops first
  assign nvm_async = {config_blank, low_voltage_programming_enable,
                      watchdog_config_raw, supervisor_config_raw};

  swc_sync #(
    .WIDTH      (SYNC_WIDTH),
    .RESET_BITS ({SYNC_WIDTH{1'b1}})
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (nvm_async),
    .sync_out (nvm_sync)
  );

  // Sync flops reset to ones, so the block reads blank until words land
  assign blank_sync = nvm_sync[SYNC_WIDTH-1];
  assign lvp_sync   = nvm_sync[SYNC_WIDTH-2];

  // Blank words read as all ones, unimplemented bits always as one
  assign sup_word = blank_sync ? CFG_BLANK
                  : (nvm_sync[CFG_WIDTH-1:0] | SUP_UNIMPL_MASK);
  assign wdt_word = blank_sync ? CFG_BLANK
                  : (nvm_sync[2*CFG_WIDTH-1:CFG_WIDTH] | WDT_UNIMPL_MASK);

  // Readback is registered so it moves in step with the settings
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      supervisor_config_word <= CFG_BLANK;
      watchdog_config_word   <= CFG_BLANK;
    end
    else
    begin
      supervisor_config_word <= sup_word;
      watchdog_config_word   <= wdt_word;
    end
  end

  // Supervisor settings
  // Settings read zero in reset; consumers must wait
  // three edges after release for decoded values
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      supervisor_settings <= SUP_SETTINGS_RESET;
    else
    begin
      supervisor_settings.debugger_enable           <= !sup_word[SUP_DEBUG_BIT];
      supervisor_settings.prog_pins_gpio            <= sup_word[SUP_DEBUG_BIT];
      supervisor_settings.stack_fault_reset_enable  <= sup_word[SUP_STACK_BIT];
      supervisor_settings.pin_select_one_way_lock   <= sup_word[SUP_PPS_BIT];
      supervisor_settings.zero_cross_detect_disable <= sup_word[SUP_ZCD_BIT];
      // Trip point only; the analog side applies it whenever brown-out is on
      supervisor_settings.brownout_trip_low         <= sup_word[SUP_BROWNOUT_TRIP_LEVEL_BIT];
      supervisor_settings.brownout_reset_active     <=
        mode_active(sup_word[SUP_BOR_MODE_LSB +: 2], sleep_active,
                    software_brownout_enable);
      supervisor_settings.low_power_brownout_enable <= !sup_word[SUP_LPBOR_BIT];
      supervisor_settings.powerup_timer_enable      <= !sup_word[SUP_PWRT_BIT];
      supervisor_settings.master_clear_active       <=
        lvp_sync | sup_word[SUP_MASTER_CLEAR_PIN_BIT];
    end
  end

  // Watchdog settings; the counter itself lives elsewhere
  // A new word only arrives by programming, so no care is taken
  // for a change in mid-period of the counter
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      watchdog_settings <= WDT_SETTINGS_RESET;
    else
    begin
      watchdog_settings.clock_source            <=
        clock_source(wdt_word[WDT_CLK_LSB +: 3]);
      watchdog_settings.window_closed_eighths   <=
        window_closed(wdt_word[WDT_WIN_LSB +: 3]);
      watchdog_settings.window_software_control <=
        window_soft(wdt_word[WDT_WIN_LSB +: 3]);
      watchdog_settings.keyed_access_required   <=
        !window_soft(wdt_word[WDT_WIN_LSB +: 3]);
      watchdog_settings.watchdog_running        <=
        mode_active(wdt_word[WDT_MODE_LSB +: 2], sleep_active,
                    software_watchdog_enable);
      watchdog_settings.prescale_log2           <=
        period_log2(wdt_word[WDT_PER_LSB +: 5]);
    end
  end

  // Return stack depth tracking; 0 means empty, 16 means full
  // Five bits hold all 17 depths
  logic push_only;
  logic pop_only;
  logic overflow_event;
  logic underflow_event;
  logic fault_event;

  // Push and pop together cancel, as a call that returns at once
  assign push_only       = stack_push && !stack_pop;
  assign pop_only        = stack_pop && !stack_push;
  assign overflow_event  = push_only && (stack_depth == STACK_LEVELS);
  assign underflow_event = pop_only && (stack_depth == STACK_EMPTY);
  assign fault_event     = (overflow_event || underflow_event)
                           && supervisor_settings.stack_fault_reset_enable;

  // Without fault reset the depth saturates at both ends; the flags
  // record the lost event and software must treat the stack as corrupt
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      stack_depth <= STACK_EMPTY;
    else if (fault_event)
      stack_depth <= STACK_EMPTY;
    else if (push_only && !overflow_event)
      stack_depth <= stack_depth + 5'h01;
    else if (pop_only && !underflow_event)
      stack_depth <= stack_depth - 5'h01;
  end

  // One-cycle reset request to the reset controller
  // The reset controller stretches it, so one cycle is enough
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      stack_fault_reset <= 1'b0;
    else
      stack_fault_reset <= fault_event;
  end

  // Sticky flags; a fault in the clearing cycle wins over the clear
  // Flags set even with fault reset off, so software can see the loss
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      stack_overflow_flag <= 1'b0;
    else if (overflow_event)
      stack_overflow_flag <= 1'b1;
    else if (stack_flag_clear)
      stack_overflow_flag <= 1'b0;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      stack_underflow_flag <= 1'b0;
    else if (underflow_event)
      stack_underflow_flag <= 1'b1;
    else if (stack_flag_clear)
      stack_underflow_flag <= 1'b0;
  end

  // Pin-select lock uses the registered one-way policy
  // The policy is valid three edges after reset; a write on the first edge
  // meets the reset policy, which toggles freely; the next two meet the blank word's one-way policy
  swc_pin_select_lock u_lock (
    .clock      (clock),
    .rstn       (rstn),
    .one_way    (supervisor_settings.pin_select_one_way_lock),
    .unlock_ok  (pin_select_unlock_ok),
    .lock_write (pin_select_lock_write),
    .lock_wdata (pin_select_lock_wdata),
    .lock_bit   (pin_select_lock_bit),
    .lock_final (pin_select_lock_final)
  );

endmodule // swc_config_decode

// [swc_pkg.sv]
// Purpose: Shared constants and types for the configuration word decoder
// Assumes: 14-bit configuration words, blank state is all ones
// Notes:   Field positions and codes are named once here
package swc_pkg;

  localparam int          CFG_WIDTH = 14;
  localparam logic [13:0] CFG_BLANK = 14'h3FFF;

  // Supervisor word fields
  localparam int          SUP_DEBUG_BIT    = 13;
  localparam int          SUP_STACK_BIT    = 12;
  localparam int          SUP_PPS_BIT      = 11;
  localparam int          SUP_ZCD_BIT      = 10;
  localparam int          SUP_BROWNOUT_TRIP_LEVEL_BIT     = 9;
  localparam int          SUP_BOR_MODE_LSB = 6;
  localparam int          SUP_LPBOR_BIT    = 5;
  localparam int          SUP_PWRT_BIT     = 1;
  localparam int          SUP_MASTER_CLEAR_PIN_BIT     = 0;
  localparam logic [13:0] SUP_UNIMPL_MASK  = 14'h011C;

  // Watchdog word fields
  localparam int          WDT_CLK_LSB     = 11;
  localparam int          WDT_WIN_LSB     = 8;
  localparam int          WDT_MODE_LSB    = 5;
  localparam int          WDT_PER_LSB     = 0;
  localparam logic [13:0] WDT_UNIMPL_MASK = 14'h0080;

  // Shared two-bit operating mode codes
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [1:0] MODE_AWAKE  = 2'h2;
  localparam logic [1:0] MODE_SOFT   = 2'h1;
  localparam logic [1:0] MODE_OFF    = 2'h0;

  localparam logic [2:0] WDT_CLK_LFOSC   = 3'h0;
  localparam logic [2:0] WDT_CLK_MFOSC16 = 3'h1;
  localparam logic [2:0] WDT_CLK_SOFT    = 3'h7;
  localparam logic [2:0] WDT_WIN_SOFT    = 3'h7;

  localparam logic [4:0] PERIOD_MAX_CODE  = 5'h12;
  localparam logic [4:0] PERIOD_BASE_LOG2 = 5'h05;

  localparam logic [4:0] STACK_LEVELS = 5'h10;
  localparam logic [4:0] STACK_EMPTY  = 5'h00;

  typedef enum logic [1:0] {
    SWC_CLK_LFOSC   = 2'b00,
    SWC_CLK_MFOSC16 = 2'b01,
    SWC_CLK_SOFT    = 2'b11,
    SWC_CLK_NONE    = 2'b10
  } swc_wdt_clk_type;

  typedef enum logic [1:0] {
    SWC_OPEN_FIRST   = 2'b00,
    SWC_LOCKED_FIRST = 2'b01,
    SWC_OPEN_AGAIN   = 2'b11,
    SWC_LOCKED_FINAL = 2'b10
  } swc_lock_state_type;

  typedef struct packed {
    logic debugger_enable;
    logic prog_pins_gpio;
    logic stack_fault_reset_enable;
    logic pin_select_one_way_lock;
    logic zero_cross_detect_disable;
    logic brownout_trip_low;
    logic brownout_reset_active;
    logic low_power_brownout_enable;
    logic powerup_timer_enable;
    logic master_clear_active;
  } swc_supervisor_type;

  typedef struct packed {
    swc_wdt_clk_type clock_source;
    logic [2:0]      window_closed_eighths;
    logic            window_software_control;
    logic            keyed_access_required;
    logic            watchdog_running;
    logic [4:0]      prescale_log2;
  } swc_watchdog_type;

  localparam swc_supervisor_type SUP_SETTINGS_RESET = '0;
  localparam swc_watchdog_type   WDT_SETTINGS_RESET = '0;

endpackage

// [swc_sync.sv]
// Purpose: Two-stage synchroniser for the nonvolatile configuration inputs
// Assumes: Inputs change rarely and only as a whole after programming
// Notes:   First stage is read by the second stage only
module swc_sync
  import swc_pkg::*;
#(
  parameter int               WIDTH      = 30,
  parameter logic [WIDTH-1:0] RESET_BITS = '1
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_reg <= RESET_BITS;
      sync_out   <= RESET_BITS;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule // swc_sync

// [swc_pin_select_lock.sv]
// Purpose: Pin-select lock bit with optional one-way policy
// Assumes: Unlock qualifier comes from core logic on the same clock
// Notes:   Lock is clear after reset; writes without unlock are dropped
module swc_pin_select_lock
  import swc_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Policy
  input  wire logic one_way,
  // Core write port
  input  wire logic unlock_ok,
  input  wire logic lock_write,
  input  wire logic lock_wdata,
  // State
  output logic      lock_bit,
  output logic      lock_final
);

  swc_lock_state_type state_reg;
  swc_lock_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    if (lock_write && unlock_ok)
    begin
      unique case (state_reg)
        SWC_OPEN_FIRST:
          if (lock_wdata)
            state_next = SWC_LOCKED_FIRST;
        SWC_LOCKED_FIRST:
          if (!lock_wdata)
            state_next = SWC_OPEN_AGAIN;
        SWC_OPEN_AGAIN:
          if (lock_wdata)
            state_next = one_way ? SWC_LOCKED_FINAL : SWC_LOCKED_FIRST;
        SWC_LOCKED_FINAL:
          if (!lock_wdata && !one_way)
            state_next = SWC_OPEN_AGAIN;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_reg <= SWC_OPEN_FIRST;
    else
      state_reg <= state_next;
  end

  // Locked codes differ in exactly one bit from each open code
  assign lock_bit   = ^state_reg;
  assign lock_final = (state_reg == SWC_LOCKED_FINAL);

endmodule // swc_pin_select_lock

// [swc_nvm_model.sv]
// Purpose: Behavioural programmer that writes the two configuration words
// Assumes: A programming pass lands whole, just after a clock edge
// Notes:   Starts erased; erase raises the blank flag
module swc_nvm_model
  import swc_pkg::*;
#(
  parameter int CORE_MHZ = 10
)
(
  // Clock
  input  wire logic        clock,
  // Programming request
  input  wire logic        load,
  input  wire logic        erase,
  input  wire logic        debug_session,
  input  wire logic        lvp_in,
  input  wire logic [13:0] sup_in,
  input  wire logic [13:0] wdt_in,
  // Stored configuration
  output logic      [13:0] supervisor_config_raw,
  output logic      [13:0] watchdog_config_raw,
  output logic             low_voltage_programming_enable,
  output logic             config_blank
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    supervisor_config_raw = CFG_BLANK;
    watchdog_config_raw = CFG_BLANK;
    low_voltage_programming_enable = 1'b0;
    config_blank = 1'b1;
  end

  // Outside a debug session the tool keeps the debugger off; fast parts get the high trip level
  always @(posedge clock)
  begin
    if (load)
    begin
      supervisor_config_raw <= (sup_in | {!debug_session, 13'h0000}) & ~{4'h0, CORE_MHZ >= 16, 9'h000};
      watchdog_config_raw <= wdt_in;
      low_voltage_programming_enable <= lvp_in;
      config_blank <= erase;
    end
  end
endmodule // swc_nvm_model

// [swc_config_decode_assertions.sv]
// Purpose: Port-level checks for the configuration decoder
// Assumes: Word changes show three edges later, core inputs one edge later
// Notes:   Bound to every instance of the decoder
module swc_config_decode_assertions
  import swc_pkg::*;
(
  // Clock and reset
  input wire logic               clock,
  input wire logic               rstn,
  // Watched inputs
  input wire logic [13:0]        supervisor_config_raw,
  input wire logic [13:0]        watchdog_config_raw,
  input wire logic               low_voltage_programming_enable,
  input wire logic               config_blank,
  input wire logic               sleep_active,
  input wire logic               software_brownout_enable,
  input wire logic               stack_push,
  input wire logic               stack_pop,
  input wire logic               pin_select_unlock_ok,
  input wire logic               pin_select_lock_write,
  input wire logic               pin_select_lock_wdata,
  // Watched outputs
  input wire swc_supervisor_type supervisor_settings,
  input wire swc_watchdog_type   watchdog_settings,
  input wire logic [13:0]        supervisor_config_word,
  input wire logic [13:0]        watchdog_config_word,
  input wire logic               stack_fault_reset,
  input wire logic               stack_overflow_flag,
  input wire logic               stack_underflow_flag,
  input wire logic [4:0]         stack_depth,
  input wire logic               pin_select_lock_bit,
  input wire logic               pin_select_lock_final
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] since_reg;
  logic       settled;

  // Word checks wait until the synchroniser holds only post-reset samples
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      since_reg <= 3'h0;
    else if (since_reg != 3'h7)
      since_reg <= since_reg + 3'h1;
  end
  assign settled = since_reg >= 3'h4;

  default clocking dc @(posedge clock); endclocking
  default disable iff (!rstn);

  sup_readback_a: assert property (settled |-> supervisor_config_word == ($past(config_blank, 3) ? CFG_BLANK :
    ($past(supervisor_config_raw, 3) | SUP_UNIMPL_MASK))) else $error("supervisor readback wrong");
  wdt_readback_a: assert property (settled |-> watchdog_config_word == ($past(config_blank, 3) ? CFG_BLANK :
    ($past(watchdog_config_raw, 3) | WDT_UNIMPL_MASK))) else $error("watchdog readback wrong");
  master_clear_pin_select_a: assert property (settled |-> supervisor_settings.master_clear_active ==
    ($past(low_voltage_programming_enable, 3) | supervisor_config_word[0])) else $error("master clear select wrong");
  bor_mode_a: assert property (settled |-> supervisor_settings.brownout_reset_active ==
    (supervisor_config_word[7:6] == MODE_ALWAYS || (supervisor_config_word[7:6] == MODE_AWAKE && !$past(sleep_active))
    || (supervisor_config_word[7:6] == MODE_SOFT && $past(software_brownout_enable)))) else $error("brown-out mode wrong");
  period_map_a: assert property (settled |-> watchdog_settings.prescale_log2 == ((watchdog_config_word[4:0] <=
    PERIOD_MAX_CODE) ? watchdog_config_word[4:0] + PERIOD_BASE_LOG2 : PERIOD_BASE_LOG2)) else $error("period wrong");
  window_key_a: assert property (settled |-> watchdog_settings.keyed_access_required !=
    watchdog_settings.window_software_control && watchdog_settings.window_software_control ==
    (watchdog_config_word[10:8] == WDT_WIN_SOFT)) else $error("window access wrong");
  overflow_reset_a: assert property (stack_push && !stack_pop && stack_depth == STACK_LEVELS &&
    supervisor_settings.stack_fault_reset_enable |=> stack_fault_reset && stack_overflow_flag
    && stack_depth == STACK_EMPTY) else $error("overflow reset missing");
  underflow_flag_a: assert property (stack_pop && !stack_push && stack_depth == STACK_EMPTY
    |=> stack_underflow_flag) else $error("underflow flag missing");
  reset_cause_a: assert property (stack_fault_reset |-> $past(stack_push ^ stack_pop))
    else $error("stack reset without stack event");
  lock_final_a: assert property (pin_select_lock_final |=> pin_select_lock_final && pin_select_lock_bit)
    else $error("final lock released");
  lock_write_a: assert property (pin_select_lock_write && pin_select_unlock_ok && !pin_select_lock_final
    |=> pin_select_lock_bit == $past(pin_select_lock_wdata)) else $error("lock write lost");
  lock_hold_a: assert property (!(pin_select_lock_write && pin_select_unlock_ok) |=> $stable(pin_select_lock_bit))
    else $error("lock changed without unlocked write");

  cover property (stack_fault_reset && stack_overflow_flag);
  cover property (pin_select_lock_final);
  cover property (settled && config_blank);
endmodule // swc_config_decode_assertions

bind swc_config_decode swc_config_decode_assertions u_chk (.*);

// [swc_config_decode_tb.sv]
// Purpose: Self-checking bench for the configuration decoder
// Assumes: Inputs driven on the falling edge, 100 ns clock
// Notes:   Table rows hold words, controls and expected readback
module swc_config_decode_tb import swc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0, rstn = 1'b0, load = 1'b0, erase = 1'b0, debug_session = 1'b1, lvp_in = 1'b0;
  logic [13:0] sup_in = 14'h0000, wdt_in = 14'h0000;
  logic [13:0] supervisor_config_raw, watchdog_config_raw, supervisor_config_word, watchdog_config_word;
  logic low_voltage_programming_enable, config_blank, stack_fault_reset, stack_overflow_flag, stack_underflow_flag;
  logic pin_select_lock_bit, pin_select_lock_final;
  logic [4:0] stack_depth;
  logic sleep_active = 1'b0, software_brownout_enable = 1'b0, software_watchdog_enable = 1'b0;
  logic stack_push = 1'b0, stack_pop = 1'b0, stack_flag_clear = 1'b0;
  logic pin_select_unlock_ok = 1'b0, pin_select_lock_write = 1'b0, pin_select_lock_wdata = 1'b0;
  swc_supervisor_type supervisor_settings;
  swc_watchdog_type   watchdog_settings;
  int error_cnt = 0, comparisons = 0, cycles = 0;
  // Controls: debug session, lvp, erase, sleep, software brown-out, software watchdog
  logic [13:0] sup_t [8] = '{14'h0000, 14'h2A42, 14'h14A1, 14'h00C0, 14'h0000, 14'h0040, 14'h3EE3, 14'h0001};
  logic [13:0] wdt_t [8] = '{14'h0000, 14'h0921, 14'h1252, 14'h1B73, 14'h0000, 14'h241F, 14'h2D25, 14'h362A};
  logic [5:0]  ctl_t [8] = '{6'h20, 6'h03, 6'h24, 6'h34, 6'h28, 6'h00, 6'h00, 6'h21};
  logic [13:0] xs_t [8]  = '{14'h011C, 14'h2B5E, 14'h15BD, 14'h01DC, 14'h3FFF, 14'h215C, 14'h3FFF, 14'h011D};
  logic [13:0] xw_t [8]  = '{14'h0080, 14'h09A1, 14'h12D2, 14'h1BF3, 14'h3FFF, 14'h249F, 14'h2DA5, 14'h36AA};

  swc_nvm_model u_nvm (.*);
  swc_config_decode u_dut (.*);

  always #50 clock = ~clock;

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] exp_sup(input logic [13:0] w, input logic l, input logic s, input logic b);
    logic bor;
    bor = (w[7:6] == 2'h3) || (w[7:6] == 2'h2 && !s) || (w[7:6] == 2'h1 && b);
    return {6'h00, !w[13], w[13], w[12], w[11], w[10], w[9], bor, !w[5], !w[1], l | w[0]};
  endfunction

  function automatic logic [15:0] exp_wdt(input logic [13:0] w, input logic s, input logic e);
    logic [1:0] c;
    logic r;
    c = (w[13:11] == 3'h0) ? 2'h0 : (w[13:11] == 3'h1) ? 2'h1 : (w[13:11] == 3'h7) ? 2'h3 : 2'h2;
    r = (w[6:5] == 2'h3) || (w[6:5] == 2'h2 && !s) || (w[6:5] == 2'h1 && e);
    return {3'h0, c, (w[10:8] < 3'h6) ? 3'h7 - w[10:8] : 3'h0, w[10:8] == 3'h7, w[10:8] != 3'h7, r,
            (w[4:0] <= 5'h12) ? w[4:0] + 5'h05 : 5'h05};
  endfunction

  task automatic ld(input logic [13:0] s, input logic [13:0] w, input logic [5:0] c);
    sup_in = s;
    wdt_in = w;
    {debug_session, lvp_in, erase, sleep_active, software_brownout_enable, software_watchdog_enable} = c;
    load = 1'b1;
    @(negedge clock);
    load = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic stk(input logic p, input logic q, input int n);
    @(negedge clock);
    repeat (n)
    begin
      stack_push = p;
      stack_pop = q;
      @(negedge clock);
    end
    stack_push = 1'b0;
    stack_pop = 1'b0;
  endtask

  task automatic lk(input logic ok, input logic d, input logic [1:0] e);
    pin_select_unlock_ok = ok;
    pin_select_lock_wdata = d;
    pin_select_lock_write = 1'b1;
    @(negedge clock);
    pin_select_lock_write = 1'b0;
    @(negedge clock);
    chk(16'({pin_select_lock_final, pin_select_lock_bit}), 16'(e));
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      ld(sup_t[i], wdt_t[i], ctl_t[i]);
      chk(16'(supervisor_config_word), 16'(xs_t[i]));
      chk(16'(watchdog_config_word), 16'(xw_t[i]));
      chk(16'(supervisor_settings), exp_sup(xs_t[i], ctl_t[i][4], ctl_t[i][2], ctl_t[i][1]));
      chk(16'(watchdog_settings), exp_wdt(xw_t[i], ctl_t[i][2], ctl_t[i][0]));
    end
    // Stack fault reset on, one-way lock policy on
    ld(14'h1800, 14'h0000, 6'h20);
    stk(1'b1, 1'b0, 16);
    chk(16'(stack_depth), 16'h0010);
    stk(1'b1, 1'b0, 1);
    chk(16'({stack_fault_reset, stack_overflow_flag, stack_underflow_flag, stack_depth}), 16'h00C0);
    stk(1'b0, 1'b1, 1);
    chk(16'({stack_fault_reset, stack_overflow_flag, stack_underflow_flag, stack_depth}), 16'h00E0);
    stk(1'b1, 1'b1, 1);
    chk(16'({stack_fault_reset, stack_overflow_flag, stack_underflow_flag, stack_depth}), 16'h0060);
    stack_flag_clear = 1'b1;
    @(negedge clock);
    stack_flag_clear = 1'b0;
    @(negedge clock);
    chk(16'({stack_overflow_flag, stack_underflow_flag}), 16'h0000);
    lk(1'b0, 1'b1, 2'b00);
    lk(1'b1, 1'b1, 2'b01);
    lk(1'b1, 1'b0, 2'b00);
    lk(1'b1, 1'b1, 2'b11);
    lk(1'b1, 1'b0, 2'b11);
    // Reset in mid-run clears the one-way lock and all settings
    rstn = 1'b0;
    @(negedge clock);
    chk(16'(supervisor_settings), 16'h0000);
    chk(16'(watchdog_settings), 16'h0000);
    chk(16'({supervisor_config_word, pin_select_lock_final, pin_select_lock_bit}), 16'hFFFC);
    rstn = 1'b1;
    // Fault reset off and free lock toggling
    ld(14'h0000, 14'h0000, 6'h20);
    stk(1'b1, 1'b0, 17);
    chk(16'({stack_fault_reset, stack_overflow_flag, stack_underflow_flag, stack_depth}), 16'h0050);
    repeat (2)
    begin
      lk(1'b1, 1'b1, 2'b01);
      lk(1'b1, 1'b0, 2'b00);
    end
    stop_test();
  end
endmodule // swc_config_decode_tb
